/* wocp_regs.svh */
// Constants of the write-only serial command port.
`ifndef WOCP_REGS_SVH
`define WOCP_REGS_SVH
`define WOCP_SLAVE_ADDR 7'h1B
`define WOCP_FORCE_BIT 19
`define WOCP_DATA_BYTES 3
`define WOCP_BUS_KHZ 400
`define WOCP_CLK_NS 10
`define WOCP_SPIKE_NS 50
`define WOCP_FILT_CYC ((`WOCP_SPIKE_NS + `WOCP_CLK_NS - 1) / `WOCP_CLK_NS)
`define WOCP_SS_US 400
`define WOCP_SS_CYC ((`WOCP_SS_US * 1000) / `WOCP_CLK_NS)
`define WOCP_CMD_RESET 24'h00_0000
`define WOCP_LEVEL_RESET 8'h00
`endif

/* wocp_pkg.sv */
// Types shared by the serial command port and its buffer.
`default_nettype none
package wocp_pkg;
  typedef struct packed {
    logic [7:0] first;
    logic [7:0] second;
    logic [7:0] third;
  } wocp_cmd_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_DATA = 3'b010,
    ST_ACK = 3'b011,
    ST_IGNORE = 3'b100
  } wocp_bus_st_t;
  typedef enum logic [1:0] {
    P_OFF = 2'b00,
    P_DIRECT = 2'b01,
    P_BOOST = 2'b10
  } wocp_pump_st_t;
endpackage
`default_nettype wire

/* wocp_buf.sv */
// Small circular buffer with valid and ready on both sides.
`timescale 1ns/1ns
`default_nettype none
`include "wocp_regs.svh"
module wocp_buf import wocp_pkg::*; #(
  parameter int DEPTH = 2,
  parameter int AW = 1
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // Filling side.
  input wire logic in_valid,
  input wire wocp_cmd_t in_data,
  output logic in_ready,
  // Draining side.
  output logic out_valid,
  output wocp_cmd_t out_data,
  input wire logic out_ready
);
  wocp_cmd_t mem_reg [DEPTH];
  wocp_cmd_t mem_next [DEPTH];
  logic [AW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  assign in_ready = cnt_reg != (AW+1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data = mem_reg[rptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    mem_next = mem_reg;
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    cnt_next = cnt_reg;
    if (push) begin
      mem_next[wptr_reg] = in_data;
      wptr_next = (wptr_reg == AW'(DEPTH - 1)) ? '0 : wptr_reg + 1'b1;
    end
    if (pop) begin
      rptr_next = (rptr_reg == AW'(DEPTH - 1)) ? '0 : rptr_reg + 1'b1;
    end
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int k = 0; k < DEPTH; k++) begin
        mem_reg[k] <= `WOCP_CMD_RESET;
      end
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
    end else if (ce) begin
      mem_reg <= mem_next;
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule
`default_nettype wire

/* wocp_top.sv */
// Write-only two-wire command slave with charge-pump mode control.
`timescale 1ns/1ns
`default_nettype none
`include "wocp_regs.svh"
module wocp_top import wocp_pkg::*; #(
  parameter int NSRC = 8,
  parameter int SOFT_START_CYCLES = `WOCP_SS_CYC,
  parameter int FILT_CYCLES = `WOCP_FILT_CYC
) (
  // Clock, reset and enable.
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic CE,
  // Two-wire bus pins.
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // Current source status.
  input wire logic [NSRC-1:0] LED_ACTIVE,
  input wire logic [NSRC-1:0] DROPOUT,
  // Committed command.
  output wocp_cmd_t COMMAND,
  output logic CMD_VALID,
  output wocp_cmd_t CMD_DATA,
  input wire logic CMD_READY,
  // Pump control.
  output logic PUMP_DIRECT,
  output logic PUMP_BOOST,
  output logic [7:0] PUMP_LEVEL
);
  localparam int STEP_CYCLES = (SOFT_START_CYCLES / 255 > 0) ? SOFT_START_CYCLES / 255 : 1;

  // Line index 1 is SCL, index 0 is SDA.
  logic [1:0] pins;
  logic [1:0] s1_reg, s2_reg, filt_reg, filt_q_reg;
  logic [1:0] s1_next, s2_next, filt_next;
  logic [3:0] fcnt_reg [2];
  logic [3:0] fcnt_next [2];

  assign pins = {SCL_IN, SDA_IN};

  // Both lines pass the same delay, so START and STOP keep their place against SCL.
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_line
      // A change must persist longer than a spike before it is believed.
      always_comb begin
        s1_next[i] = pins[i];
        s2_next[i] = s1_reg[i];
        filt_next[i] = filt_reg[i];
        fcnt_next[i] = 4'h0;
        if (s2_reg[i] != filt_reg[i]) begin
          if (fcnt_reg[i] == 4'(FILT_CYCLES - 1)) begin
            filt_next[i] = s2_reg[i];
          end else begin
            fcnt_next[i] = fcnt_reg[i] + 4'h1;
          end
        end
      end

      always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          s1_reg[i] <= 1'b1;
          s2_reg[i] <= 1'b1;
          filt_reg[i] <= 1'b1;
          filt_q_reg[i] <= 1'b1;
          fcnt_reg[i] <= 4'h0;
        end else if (CE) begin
          s1_reg[i] <= s1_next[i];
          s2_reg[i] <= s2_next[i];
          filt_reg[i] <= filt_next[i];
          filt_q_reg[i] <= filt_reg[i];
          fcnt_reg[i] <= fcnt_next[i];
        end
      end
    end
  endgenerate

  logic scl_f, sda_f, scl_rise, scl_fall, start_det, stop_det;
  assign scl_f = filt_reg[1];
  assign sda_f = filt_reg[0];
  assign scl_rise = scl_f && !filt_q_reg[1];
  assign scl_fall = !scl_f && filt_q_reg[1];
  assign start_det = scl_f && filt_q_reg[1] && !sda_f && filt_q_reg[0];
  assign stop_det = scl_f && filt_q_reg[1] && sda_f && !filt_q_reg[0];

  // Receive engine.
  wocp_bus_st_t st_reg, st_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] shift_reg, shift_next;
  logic [1:0] idx_reg, idx_next;
  wocp_cmd_t hold_reg, hold_next, cmd_reg, cmd_next;
  logic full_reg, full_next, oe_reg, oe_next;
  logic commit, buf_in_ready, byte_end;

  assign byte_end = scl_fall && (bit_reg == 4'h8);

  // A condition overrides any bit in flight, so a cut byte never reaches the latches.
  always_comb begin
    st_next = st_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    idx_next = idx_reg;
    hold_next = hold_reg;
    cmd_next = cmd_reg;
    full_next = full_reg;
    oe_next = oe_reg;
    commit = 1'b0;
    if (start_det) begin
      st_next = ST_ADDR;
      bit_next = 4'h0;
      oe_next = 1'b0;
    end else if (stop_det) begin
      st_next = ST_IDLE;
      oe_next = 1'b0;
      if (full_reg) begin
        commit = 1'b1;
        cmd_next = hold_reg;
        full_next = 1'b0;
      end
    end else begin
      unique case (st_reg)
        ST_IDLE, ST_IGNORE: begin
        end
        ST_ADDR, ST_DATA: begin
          if (scl_rise && bit_reg != 4'h8) begin
            shift_next = {shift_reg[6:0], sda_f};
            bit_next = bit_reg + 4'h1;
          end
          if (byte_end && st_reg == ST_ADDR) begin
            // A full buffer refuses the address so no committed word is lost.
            if (shift_reg == {`WOCP_SLAVE_ADDR, 1'b0} && buf_in_ready) begin
              oe_next = 1'b1;
              st_next = ST_ACK;
              idx_next = 2'h0;
              full_next = 1'b0;
            end else begin
              st_next = ST_IGNORE;
            end
          end else if (byte_end) begin
            oe_next = 1'b1;
            st_next = ST_ACK;
            unique case (idx_reg)
              2'h0: hold_next.first = shift_reg;
              2'h1: hold_next.second = shift_reg;
              default: hold_next.third = shift_reg;
            endcase
            if (idx_reg == 2'(`WOCP_DATA_BYTES - 1)) begin
              full_next = 1'b1;
            end else begin
              idx_next = idx_reg + 2'h1;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            oe_next = 1'b0;
            bit_next = 4'h0;
            st_next = full_reg ? ST_IGNORE : ST_DATA;
          end
        end
        default: begin
          st_next = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_reg <= ST_IDLE;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      idx_reg <= 2'h0;
      hold_reg <= `WOCP_CMD_RESET;
      cmd_reg <= `WOCP_CMD_RESET;
      full_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else if (CE) begin
      st_reg <= st_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      idx_reg <= idx_next;
      hold_reg <= hold_next;
      cmd_reg <= cmd_next;
      full_reg <= full_next;
      oe_reg <= oe_next;
    end
  end

  // The pin is only ever pulled low; read data never exists.
  assign SDA_OUT = 1'b0;
  assign SDA_OE = oe_reg;
  assign COMMAND = cmd_reg;

  // A stalled consumer fills the buffer, and the address is then refused instead of a word lost.
  wocp_buf #(
    .DEPTH(2),
    .AW(1)
  ) u_buf (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .ce(CE),
    .in_valid(commit),
    .in_data(hold_reg),
    .in_ready(buf_in_ready),
    .out_valid(CMD_VALID),
    .out_data(CMD_DATA),
    .out_ready(CMD_READY)
  );

  // Pump mode control.
  // Boost never steps back to direct; the pump stops only when nothing is enabled or forced.
  wocp_pump_st_t pump_reg, pump_next;
  logic [15:0] step_reg, step_next;
  logic [7:0] level_reg, level_next;
  logic enabled, boost_req, force_on;

  assign enabled = |LED_ACTIVE;
  assign boost_req = |(DROPOUT & LED_ACTIVE);
  assign force_on = cmd_reg[`WOCP_FORCE_BIT];

  always_comb begin
    pump_next = pump_reg;
    step_next = step_reg;
    level_next = level_reg;
    unique case (pump_reg)
      P_OFF: begin
        if (force_on) begin
          pump_next = P_BOOST;
        end else if (enabled) begin
          pump_next = P_DIRECT;
        end
      end
      P_DIRECT: begin
        if (!enabled && !force_on) begin
          pump_next = P_OFF;
        end else if (boost_req || force_on) begin
          pump_next = P_BOOST;
        end
      end
      P_BOOST: begin
        if (!enabled && !force_on) begin
          pump_next = P_OFF;
        end else if (level_reg != 8'hFF) begin
          // One step per fixed interval gives a linear ramp to full strength.
          if (step_reg == 16'(STEP_CYCLES - 1)) begin
            step_next = 16'h0000;
            level_next = level_reg + 8'h01;
          end else begin
            step_next = step_reg + 16'h0001;
          end
        end
      end
      default: begin
        pump_next = P_OFF;
      end
    endcase
    if (pump_next != P_BOOST) begin
      step_next = 16'h0000;
      level_next = `WOCP_LEVEL_RESET;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pump_reg <= P_OFF;
      step_reg <= 16'h0000;
      level_reg <= `WOCP_LEVEL_RESET;
    end else if (CE) begin
      pump_reg <= pump_next;
      step_reg <= step_next;
      level_reg <= level_next;
    end
  end

  assign PUMP_DIRECT = pump_reg == P_DIRECT;
  assign PUMP_BOOST = pump_reg == P_BOOST;
  assign PUMP_LEVEL = level_reg;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N || !CE);

  sequence own_addr_end;
    st_reg == ST_ADDR && byte_end && !start_det && !stop_det;
  endsequence
  sequence data_end_first;
    st_reg == ST_DATA && byte_end && idx_reg == 2'h0 && !start_det && !stop_det;
  endsequence
  sequence data_end_third;
    st_reg == ST_DATA && byte_end && idx_reg == 2'h2 && !start_det && !stop_det;
  endsequence
  sequence ack_pulse_high;
    oe_reg && scl_f && !start_det && !stop_det;
  endsequence

  a_sda_only_low: assert property (SDA_OE |-> !SDA_OUT && st_reg == ST_ACK)
    else $error("SDA driven outside an acknowledge");
  a_filter_hold: assert property ($rose(scl_f)
    |-> $past(s2_reg[1]) && $past(s2_reg[1], 5))
    else $error("SCL edge passed the filter too early");
  a_filter_sda: assert property ($fell(sda_f)
    |-> !$past(s2_reg[0]) && !$past(s2_reg[0], 5))
    else $error("SDA edge passed the filter too early");
  a_start_seen: assert property (start_det |=> st_reg == ST_ADDR && bit_reg == 4'h0)
    else $error("START not taken");
  a_ack_release: assert property ($fell(oe_reg)
    |-> !scl_f || $past(stop_det) || $past(start_det))
    else $error("Acknowledge released during SCL high");
  a_ack_steady: assert property (ack_pulse_high |=> oe_reg)
    else $error("Acknowledge dropped while SCL high");
  a_addr_ack: assert property (own_addr_end ##0 (shift_reg == 8'h36 && buf_in_ready)
    |=> oe_reg && !full_reg)
    else $error("Own address not acknowledged");
  a_read_nack: assert property (own_addr_end ##0 shift_reg[0] |=> st_reg == ST_IGNORE && !oe_reg)
    else $error("Read direction acknowledged");
  a_hold_byte: assert property (data_end_first |=> hold_reg.first == $past(shift_reg))
    else $error("Data byte not latched on acknowledge");
  a_stop_commit: assert property (stop_det && full_reg |=> cmd_reg == $past(hold_reg) && !full_reg)
    else $error("Complete set not committed on STOP");
  a_early_stop: assert property (stop_det && !full_reg |=> $stable(cmd_reg))
    else $error("Command changed on early STOP");
  a_boost_entry: assert property (pump_reg == P_DIRECT && boost_req && enabled
    |=> pump_reg == P_BOOST && level_reg == 8'h00)
    else $error("Dropout did not start soft-started boost");
  a_ramp_rise: assert property (pump_reg == P_BOOST && $past(pump_reg) == P_BOOST
    |-> level_reg >= $past(level_reg))
    else $error("Soft-start level fell");
  a_ramp_step: assert property (pump_reg == P_BOOST && $past(pump_reg) == P_BOOST
    |-> level_reg - $past(level_reg) <= 8'h01)
    else $error("Soft-start level jumped");
  a_force_run: assert property (pump_reg == P_OFF && force_on |=> pump_reg == P_BOOST)
    else $error("Force bit did not start pump");
  a_set_complete: assert property (data_end_third |=> full_reg && oe_reg)
    else $error("Third data byte did not complete the set");
  a_pending_keep: assert property (start_det && full_reg |=> full_reg)
    else $error("Pending set lost at repeated START");
  a_direct_entry: assert property (pump_reg == P_OFF && enabled && !force_on
    |=> pump_reg == P_DIRECT)
    else $error("Enabled display did not select direct mode");
endmodule
`default_nettype wire

/* wocp_master.sv */
// Two-wire bus master model that writes bytes to the command port.
`timescale 1ns/1ns
`default_nettype none
module wocp_master (
  // Pacing clock.
  input wire logic clk,
  // Bus lines; SDA is released high through the pull-up.
  output logic scl,
  output logic sda_drv,
  input wire logic sda_line
);
  // Low 1300 ns plus the 200 ns data delay, then high 1200 ns, gives a 2700 ns bit, about 370 kHz.
  localparam int TLO = 130;
  localparam int THI = 120;
  logic spike = 1'b0;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Works from idle and as a repeated start after an acknowledge.
  task automatic start();
    sda_drv = 1'b1;
    wt(TLO);
    scl = 1'b1;
    wt(THI);
    sda_drv = 1'b0;
    wt(THI);
    scl = 1'b0;
    wt(20);
  endtask
  task automatic stop();
    sda_drv = 1'b0;
    wt(TLO);
    scl = 1'b1;
    wt(THI);
    sda_drv = 1'b1;
    wt(TLO);
  endtask
  // Data moves 20 cycles after the fall, so without spikes the filters never see both lines move at once.
  task automatic send(input logic [7:0] b, output logic ack);
    logic a0;
    for (int i = 7; i >= 0; i--) begin
      sda_drv = b[i];
      if (spike) begin
        scl = 1'b1;
        wt(3);
        scl = 1'b0;
      end
      wt(TLO);
      scl = 1'b1;
      wt(THI);
      scl = 1'b0;
      wt(20);
    end
    sda_drv = 1'b1;
    wt(TLO);
    scl = 1'b1;
    wt(2);
    a0 = ~sda_line;
    wt(THI - 4);
    ack = a0 & ~sda_line;
    wt(2);
    scl = 1'b0;
    wt(20);
  endtask
endmodule
`default_nettype wire

/* write_only_serial_command_port_test.sv */
// Self-checking bench for the command port and its pump control.
`timescale 1ns/1ns
`default_nettype none
module write_only_serial_command_port_test import wocp_pkg::*;;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_ready = 1'b0;
  logic ce = 1'b1;
  logic [7:0] led_active = 8'h00;
  logic [7:0] dropout = 8'h00;
  logic scl, sda_drv, sda_oe, sda_out, sda_line, cmd_valid, pump_direct, pump_boost, ack;
  logic [7:0] pump_level;
  wocp_cmd_t command, cmd_data;
  int bad_count = 0;
  int tests_run = 0;
  always #5 ref_clk = ~ref_clk;
  assign sda_line = sda_drv & (sda_oe ? sda_out : 1'b1);
  wocp_master m (.clk(ref_clk), .scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));
  wocp_top #(.NSRC(8), .SOFT_START_CYCLES(255)) dut (
    .REF_CLK(ref_clk), .ARST_N(arst_n), .CE(ce), .SCL_IN(scl), .SDA_IN(sda_line),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .LED_ACTIVE(led_active), .DROPOUT(dropout),
    .COMMAND(command), .CMD_VALID(cmd_valid), .CMD_DATA(cmd_data), .CMD_READY(cmd_ready),
    .PUMP_DIRECT(pump_direct), .PUMP_BOOST(pump_boost), .PUMP_LEVEL(pump_level));
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Sends an address byte and n data bytes, most significant first.
  task automatic frame(input logic [7:0] adr, input logic [23:0] d, input int n, input logic ea);
    m.send(adr, ack);
    chk({23'h0, ack}, {23'h0, ea});
    for (int i = 0; i < n; i++) begin
      m.send(d[23 - 8 * i -: 8], ack);
      chk({23'h0, ack}, 24'h00_0001);
    end
  endtask
  task automatic t_reset();
    chk(command, 24'h00_0000);
    chk(cmd_data, 24'h00_0000);
    chk({22'h0, sda_oe, cmd_valid}, 24'h00_0000);
    chk({14'h0, pump_direct, pump_boost, pump_level}, 24'h00_0000);
    $display("test reset done");
  endtask
  // Spikes shorter than the filter ride on every data bit and must not add clocks.
  task automatic t_write();
    m.spike = 1'b1;
    m.start();
    frame(8'h36, 24'h12_3456, 3, 1'b1);
    m.stop();
    m.spike = 1'b0;
    chk(command, 24'h12_3456);
    chk(cmd_data, 24'h12_3456);
    chk({23'h0, cmd_valid}, 24'h00_0001);
    $display("test write done");
  endtask
  task automatic t_pending();
    m.start();
    frame(8'h36, 24'h21_4365, 3, 1'b1);
    m.start();
    frame(8'h50, 24'h00_0000, 0, 1'b0);
    m.start();
    frame(8'h52, 24'h00_0000, 0, 1'b0);
    chk(command, 24'h12_3456);
    m.stop();
    chk(command, 24'h21_4365);
    $display("test pending done");
  endtask
  // Two words wait unread, so the address is refused, then both drain in order.
  task automatic t_full();
    m.start();
    frame(8'h36, 24'h00_0000, 0, 1'b0);
    m.stop();
    chk(command, 24'h21_4365);
    chk(cmd_data, 24'h12_3456);
    cmd_ready = 1'b1;
    tick(1);
    chk(cmd_data, 24'h21_4365);
    chk({23'h0, cmd_valid}, 24'h00_0001);
    tick(1);
    cmd_ready = 1'b0;
    chk({23'h0, cmd_valid}, 24'h00_0000);
    $display("test full done");
  endtask
  task automatic t_read();
    m.start();
    frame(8'h37, 24'h00_0000, 0, 1'b0);
    m.send(8'h08, ack);
    chk({23'h0, ack}, 24'h00_0000);
    m.stop();
    chk(command, 24'h21_4365);
    m.start();
    frame(8'h36, 24'h44_0000, 1, 1'b1);
    m.stop();
    chk(command, 24'h21_4365);
    chk({23'h0, cmd_valid}, 24'h00_0000);
    $display("test refused done");
  endtask
  task automatic t_readdr();
    m.start();
    frame(8'h36, 24'h55_6677, 3, 1'b1);
    m.start();
    frame(8'h36, 24'h66_0000, 1, 1'b1);
    m.stop();
    chk(command, 24'h21_4365);
    $display("test readdress done");
  endtask
  task automatic t_pump();
    int n;
    led_active = 8'h01;
    tick(3);
    chk({22'h0, pump_direct, pump_boost}, 24'h00_0002);
    dropout = 8'h02;
    tick(3);
    chk({22'h0, pump_direct, pump_boost}, 24'h00_0002);
    dropout = 8'h03;
    tick(3);
    chk({22'h0, pump_direct, pump_boost}, 24'h00_0001);
    chk({23'h0, pump_level < 8'h10}, 24'h00_0001);
    ce = 1'b0;
    tick(5);
    chk({16'h0, pump_level}, 24'h00_0002);
    ce = 1'b1;
    n = 0;
    while (pump_level !== 8'hFF && n < 400) begin
      tick(1);
      n++;
    end
    chk({23'h0, n == 253}, 24'h00_0001);
    tick(5);
    chk({16'h0, pump_level}, 24'h00_00FF);
    led_active = 8'h00;
    dropout = 8'h00;
    tick(3);
    chk({22'h0, pump_direct, pump_boost}, 24'h00_0000);
    $display("test pump done");
  endtask
  task automatic t_force();
    m.start();
    frame(8'h36, 24'h77_0000, 3, 1'b1);
    m.start();
    frame(8'h36, 24'h08_0102, 3, 1'b1);
    m.stop();
    chk(command, 24'h08_0102);
    chk(cmd_data, 24'h08_0102);
    chk({23'h0, cmd_valid}, 24'h00_0001);
    tick(3);
    chk({23'h0, pump_boost}, 24'h00_0001);
    $display("test force done");
  endtask
  initial begin
    tick(20);
    arst_n = 1'b1;
    tick(2);
    t_reset();
    t_write();
    t_pending();
    t_full();
    t_read();
    t_readdr();
    t_pump();
    t_force();
    stop_test();
  end
endmodule
`default_nettype wire
